// ==== core/drb_pkg.sv ====
// package: constants, types and register map of the dram refresh and bus arbiter
package drb_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ------------------------------------------------------------
  localparam logic [7:0] DRB_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] DRB_STATUS_ADDR = 8'h04;

  // ctrl fields
  localparam int CTRL_HIDDEN_BIT   = 0;
  localparam int CTRL_VL_FIFO_BIT  = 1;
  localparam int CTRL_CADLY_BIT    = 2;
  localparam int CTRL_WB_CACHE_BIT = 3;
  localparam int CTRL_SIZE_LSB     = 4;
  localparam int CTRL_SIZE_MSB     = 5;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

  // status fields
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_STATE_MSB  = 3;
  localparam int STAT_RPEND_BIT  = 4;
  localparam int STAT_HIDDEN_BIT = 5;
  localparam int STAT_DMA8_BIT   = 6;
  localparam int STAT_DMA16_BIT  = 7;
  localparam int STAT_MASTER_BIT = 8;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int REFRESH_PERIOD_NS = 15000;
  localparam int REFRESH_CYCLES    = (REFRESH_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int RAS_PULSE_CYC     = 3;
  localparam int CBR_LEAD_CYC      = 1;
  localparam int CASTOUT_WAIT_CYC  = 4;
  localparam int LCLK_CNT_W        = 4;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] SIZE_256K = 2'h0;
  localparam logic [1:0] SIZE_1M   = 2'h1;
  localparam logic [1:0] SIZE_4M   = 2'h2;
  localparam int MA_W = 11;

  typedef enum logic [3:0] {
    ST_IDLE, ST_HOLD_REQ, ST_REF_CBR_CAS, ST_REF_RAS, ST_REF_DONE,
    ST_ISA_GRANT, ST_VL_GRANT, ST_VL_DRAIN, ST_HID_CAS, ST_HID_RAS
  } drb_state_t;

  typedef enum logic [1:0] { OWN_NONE, OWN_REF, OWN_ISA, OWN_VL } drb_owner_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } drb_apb_req_t;

  typedef struct packed {
    logic        hidden;
    logic        vl_fifo;
    logic        cadly_long;
    logic        wb_cache;
    logic [1:0]  dram_size;
  } drb_cfg_t;

endpackage

// ==== core/drb_arbiter.sv ====
// refresh, dram address muxing and system bus arbitration
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - after reset refresh is normal: cpu held, one cycle refreshes dram and at bus
// - hidden mode: cpu dram or at access during refresh waits until free
// - hidden mode: dram refresh separate from at refresh; dram arbitrates cpu vs refresh
// - every dram refresh is cas-before-ras, no row address
// - refresh requested by 15us timer output or by a 16-bit isa master owning bus
// - column address lines 0..8 from cpu bits 3..11 for every size
// - row lines 0..8 from bits 12..20; line 9 and 10 per dram size
// - column bits 3 and 4 come from internal burst counter
// - dma/master: commands start ras, column address after programmable lclk delay
// - dma/master: cas one lclk after column address
// - write-back cache on: dma/master column address and cas wait until castout burst completes
// - cpu hold asserted for dma, at master, vl master and normal refresh
// - after hold ack issue refresh command or isa grant per requester
// - hidden refresh keeps cpu hold negated
// - requests served fifo; refresh behind isa latched, served right after
// - during isa grant dma enables mark 8/16-bit dma, else external master
// - refresh preempts vl master unless fifo option programmed
// - at refresh: companion asserts refresh and memory read commands
module drb_arbiter
  import drb_pkg::*;
#(
  parameter int REFRESH_CNT = REFRESH_CYCLES
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               timer_refresh_output,
  input  wire logic               isa_master_refresh_n,
  input  wire logic               isa_hold_request,
  input  wire logic               vl_bus_request_n,
  input  wire logic               vl_transaction_done,
  input  wire logic               cpu_hold_ack,
  input  wire logic               dma8_addr_enable_n,
  input  wire logic               dma16_addr_enable_n,
  input  wire logic               lclk,
  input  wire logic               isa_mem_cmd_n,
  input  wire logic               cpu_dram_req,
  input  wire logic               cpu_at_req,
  input  wire logic               cpu_castout_busy,
  input  wire logic [24:3]        cpu_addr,
  input  wire logic               cpu_row_phase,
  input  wire logic               burst_start,
  input  wire logic               burst_step,
  output logic                    cpu_hold,
  output logic                    isa_grant_ack,
  output logic                    vl_bus_grant_n,
  output logic                    refresh_cmd_n,
  output logic                    at_refresh_req,
  output logic                    cpu_wait,
  output logic                    ras_n,
  output logic                    cas_n,
  output logic [MA_W-1:0]         dram_mux_address
);

  // ------------------------------------------------------------
  // synchronisers for pins from other domains
  // ------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw, s1_reg, s2_reg, s3_reg, pin_reg;
  assign pin_raw = {timer_refresh_output, isa_master_refresh_n, isa_hold_request,
                    vl_bus_request_n, lclk, isa_mem_cmd_n, vl_transaction_done};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg  <= 7'h7C;
      s2_reg  <= 7'h7C;
      s3_reg  <= 7'h7C;
      pin_reg <= 7'h7C;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  logic tmr_s, isa_ref_n_s, hrq_s, vlreq_n_s, lclk_s, memcmd_n_s, vldone_s;
  assign {tmr_s, isa_ref_n_s, hrq_s, vlreq_n_s, lclk_s, memcmd_n_s, vldone_s} = pin_reg;

  logic tmr_d_reg, isa_ref_d_reg, lclk_d_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_d_reg     <= 1'b0;
      isa_ref_d_reg <= 1'b1;
      lclk_d_reg    <= 1'b0;
    end else begin
      tmr_d_reg     <= tmr_s;
      isa_ref_d_reg <= isa_ref_n_s;
      lclk_d_reg    <= lclk_s;
    end
  end

  logic lclk_rise;
  assign lclk_rise = lclk_s & ~lclk_d_reg;

  // ------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------
  drb_apb_req_t apb;
  drb_cfg_t     cfg_reg;
  drb_state_t   state_reg;
  logic         ref_pend_reg, hidden_active_reg;
  assign apb = '{psel, penable, pwrite, paddr, pwdata};

  logic apb_access;
  assign apb_access = apb.psel & apb.penable;

  function automatic logic addr_known(input logic [7:0] a);
    return (a == DRB_CTRL_ADDR) || (a == DRB_STATUS_ADDR);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= drb_cfg_t'(CTRL_RESET_VAL[5:0]);
    end else if (apb_access && apb.pwrite && apb.paddr == DRB_CTRL_ADDR) begin
      cfg_reg.hidden     <= apb.pwdata[CTRL_HIDDEN_BIT];
      cfg_reg.vl_fifo    <= apb.pwdata[CTRL_VL_FIFO_BIT];
      cfg_reg.cadly_long <= apb.pwdata[CTRL_CADLY_BIT];
      cfg_reg.wb_cache   <= apb.pwdata[CTRL_WB_CACHE_BIT];
      cfg_reg.dram_size  <= apb.pwdata[CTRL_SIZE_MSB:CTRL_SIZE_LSB];
    end
  end

  // answer takes no wait cycle: pready pulses in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb.psel & ~apb.penable;
      pslverr <= apb.psel & ~apb.penable & ~addr_known(apb.paddr);
      prdata  <= 32'h0000_0000;
      if (apb.psel && !apb.penable && !apb.pwrite) begin
        if (apb.paddr == DRB_CTRL_ADDR) begin
          prdata[CTRL_SIZE_MSB:0] <= {cfg_reg.dram_size, cfg_reg.wb_cache,
                                      cfg_reg.cadly_long, cfg_reg.vl_fifo, cfg_reg.hidden};
        end else if (apb.paddr == DRB_STATUS_ADDR) begin
          prdata[STAT_STATE_MSB:STAT_STATE_LSB] <= state_reg;
          prdata[STAT_RPEND_BIT]  <= ref_pend_reg;
          prdata[STAT_HIDDEN_BIT] <= hidden_active_reg;
          prdata[STAT_DMA8_BIT]   <= isa_grant_ack & ~dma8_addr_enable_n;
          prdata[STAT_DMA16_BIT]  <= isa_grant_ack & ~dma16_addr_enable_n;
          prdata[STAT_MASTER_BIT] <= isa_grant_ack & dma8_addr_enable_n
                                     & dma16_addr_enable_n;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // refresh request latch and fifo order
  // ------------------------------------------------------------
  logic ref_event, ref_taken, isa_first_reg, ref_first_reg;
  // an isa master owning the bus refreshes itself; timer also requests
  assign ref_event = (tmr_s & ~tmr_d_reg) | (~isa_ref_n_s & isa_ref_d_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_pend_reg <= 1'b0;
    end else if (ref_event) begin
      ref_pend_reg <= 1'b1; // set wins over the clear
    end else if (ref_taken) begin
      ref_pend_reg <= 1'b0;
    end
  end

  // remember who asked first while both wait for the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isa_first_reg <= 1'b0;
      ref_first_reg <= 1'b0;
    end else begin
      isa_first_reg <= hrq_s & (isa_first_reg | ~ref_pend_reg);
      ref_first_reg <= (ref_pend_reg | ref_event) & (ref_first_reg | ~hrq_s);
    end
  end

  // ------------------------------------------------------------
  // arbitration state machine
  // ------------------------------------------------------------
  logic [LCLK_CNT_W-1:0] cnt_reg;
  drb_owner_t            want_reg;
  logic [$clog2(REFRESH_CNT+1)-1:0] ref_age_reg;

  // clear only where the machine really leaves for a refresh, so a deferred hidden
  // refresh or a vl master in fifo mode does not lose the request
  assign ref_taken = ref_pend_reg
                     && ((state_reg == ST_IDLE && !isa_first_reg
                          && !(cfg_reg.hidden && cpu_dram_req))
                         || (state_reg == ST_VL_GRANT && !vlreq_n_s && !cfg_reg.vl_fifo));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg         <= ST_IDLE;
      want_reg          <= OWN_NONE;
      cnt_reg           <= '0;
      hidden_active_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (ref_pend_reg && !isa_first_reg) begin
            hidden_active_reg <= cfg_reg.hidden; // sampled per request
            if (cfg_reg.hidden) begin
              state_reg <= cpu_dram_req ? ST_IDLE : ST_HID_CAS;
            end else begin
              want_reg  <= OWN_REF;
              state_reg <= ST_HOLD_REQ;
            end
          end else if (hrq_s) begin
            want_reg  <= OWN_ISA;
            state_reg <= ST_HOLD_REQ;
          end else if (!vlreq_n_s) begin
            want_reg  <= OWN_VL;
            state_reg <= ST_HOLD_REQ;
          end
        end
        ST_HOLD_REQ: begin
          if (cpu_hold_ack) begin // cpu finished its own cycle first
            case (want_reg)
              OWN_REF: state_reg <= ST_REF_CBR_CAS;
              OWN_ISA: state_reg <= ST_ISA_GRANT;
              default: state_reg <= ST_VL_GRANT;
            endcase
            cnt_reg <= '0;
          end
        end
        ST_REF_CBR_CAS, ST_HID_CAS: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == LCLK_CNT_W'(CBR_LEAD_CYC)) begin
            state_reg <= (state_reg == ST_HID_CAS) ? ST_HID_RAS : ST_REF_RAS;
            cnt_reg   <= '0;
          end
        end
        ST_REF_RAS, ST_HID_RAS: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == LCLK_CNT_W'(RAS_PULSE_CYC)) begin
            state_reg <= (state_reg == ST_HID_RAS) ? ST_IDLE : ST_REF_DONE;
          end
        end
        ST_REF_DONE: begin
          hidden_active_reg <= 1'b0;
          want_reg          <= OWN_NONE;
          state_reg         <= ST_IDLE;
        end
        ST_ISA_GRANT: begin
          if (!hrq_s) begin
            want_reg  <= OWN_NONE;
            state_reg <= ST_IDLE; // latched refresh follows at once
          end
        end
        ST_VL_GRANT: begin
          if (vlreq_n_s) begin
            state_reg <= ST_IDLE;
          end else if (ref_pend_reg && !cfg_reg.vl_fifo) begin
            state_reg <= ST_VL_DRAIN;
          end
        end
        default: begin // ST_VL_DRAIN: grant withdrawn, wait for transaction end
          if (vldone_s || vlreq_n_s) begin
            want_reg  <= OWN_REF;
            state_reg <= ST_REF_CBR_CAS;
            cnt_reg   <= '0;
          end
        end
      endcase
      if (state_reg == ST_HID_RAS && cnt_reg == LCLK_CNT_W'(RAS_PULSE_CYC)) begin
        hidden_active_reg <= 1'b0;
      end
    end
  end

  // age of a grant to an isa master, counted up to REFRESH_CNT; no output or status bit reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_age_reg <= '0;
    end else if (state_reg != ST_ISA_GRANT || ref_event) begin
      ref_age_reg <= '0; // master refreshing itself restarts the age
    end else if (ref_age_reg != ($bits(ref_age_reg))'(REFRESH_CNT)) begin
      ref_age_reg <= ref_age_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // dma / master dram timing on lclk
  // ------------------------------------------------------------
  logic       dm_ras_reg, dm_col_reg, dm_cas_reg;
  logic [1:0] dm_lclk_reg;
  logic       castout_wait_reg;
  logic [2:0] castout_cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      castout_cnt_reg  <= '0;
      castout_wait_reg <= 1'b0;
    end else if (cpu_castout_busy) begin
      castout_wait_reg <= cfg_reg.wb_cache;
      castout_cnt_reg  <= 3'(CASTOUT_WAIT_CYC);
    end else if (castout_cnt_reg != '0) begin
      castout_cnt_reg <= castout_cnt_reg - 1'b1;
    end else begin
      castout_wait_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dm_ras_reg  <= 1'b0;
      dm_col_reg  <= 1'b0;
      dm_cas_reg  <= 1'b0;
      dm_lclk_reg <= '0;
    end else if (state_reg != ST_ISA_GRANT || memcmd_n_s) begin
      dm_ras_reg  <= 1'b0;
      dm_col_reg  <= 1'b0;
      dm_cas_reg  <= 1'b0;
      dm_lclk_reg <= '0;
    end else begin
      dm_ras_reg <= 1'b1; // command starts ras directly
      if (lclk_rise && !castout_wait_reg) begin
        dm_lclk_reg <= dm_lclk_reg + 1'b1;
        if (!dm_col_reg && (!cfg_reg.cadly_long || dm_lclk_reg != 2'h0)) begin
          dm_col_reg <= 1'b1;
        end else if (dm_col_reg) begin
          dm_cas_reg <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // burst counter and address mux
  // ------------------------------------------------------------
  logic [1:0] burst_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_reg <= '0;
    end else if (burst_start) begin
      burst_reg <= cpu_addr[4:3];
    end else if (burst_step) begin
      burst_reg <= burst_reg + 1'b1;
    end
  end

  function automatic logic [MA_W-1:0] mux_addr(input logic [24:3] a, input logic [1:0] b,
                                               input logic row, input logic [1:0] sz);
    logic [MA_W-1:0] m;
    m = '0;
    if (row) begin
      m[8:0] = a[20:12];
      if (sz != SIZE_256K) m[9] = a[21];
      if (sz == SIZE_4M)   m[10] = a[23];
    end else begin
      m[8:0] = {a[11:5], b};
      if (sz != SIZE_256K) m[9] = a[22];
      if (sz == SIZE_4M)   m[10] = a[24];
    end
    return m;
  endfunction

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic ref_cas, ref_ras, busy_ref, dm_row;
  assign ref_cas  = state_reg inside {ST_REF_CBR_CAS, ST_REF_RAS, ST_HID_CAS, ST_HID_RAS};
  assign ref_ras  = state_reg inside {ST_REF_RAS, ST_HID_RAS};
  assign busy_ref = state_reg inside {ST_HID_CAS, ST_HID_RAS};
  assign dm_row   = dm_ras_reg & ~dm_col_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_hold         <= 1'b0;
      isa_grant_ack    <= 1'b0;
      vl_bus_grant_n   <= 1'b1;
      refresh_cmd_n    <= 1'b1;
      at_refresh_req   <= 1'b0;
      cpu_wait         <= 1'b0;
      ras_n            <= 1'b1;
      cas_n            <= 1'b1;
      dram_mux_address <= '0;
    end else begin
      // hidden refresh never raises hold
      cpu_hold       <= !(state_reg inside {ST_IDLE, ST_HID_CAS, ST_HID_RAS});
      isa_grant_ack  <= state_reg == ST_ISA_GRANT;
      vl_bus_grant_n <= state_reg != ST_VL_GRANT;
      refresh_cmd_n  <= !(ref_cas && !hidden_active_reg);
      // normal refresh covers at memory too; hidden hands it over separately
      at_refresh_req <= (ref_cas && !hidden_active_reg) || busy_ref;
      cpu_wait       <= busy_ref && (cpu_dram_req || cpu_at_req);
      ras_n          <= !(ref_ras || dm_ras_reg);
      cas_n          <= !(ref_cas || dm_cas_reg);
      dram_mux_address <= ref_cas ? '0 :
                          mux_addr(cpu_addr, burst_reg, cpu_row_phase | dm_row,
                                   cfg_reg.dram_size);
    end
  end

endmodule

`default_nettype wire

// ==== tb/drb_cpu_model.sv ====
// host cpu model: answers the hold request after a set delay
`timescale 1ns/10ps
`default_nettype none
module drb_cpu_model #(
  parameter int ACK_DLY = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic cpu_hold,
  output logic      cpu_hold_ack
);
  // ------------------------------------------------------------
  // hold handshake
  // ------------------------------------------------------------
  // the delay stands for the bus cycle the cpu must finish first
  logic [3:0] wait_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg     <= 4'h0;
      cpu_hold_ack <= 1'h0;
    end else if (!cpu_hold) begin
      wait_reg     <= 4'h0;
      cpu_hold_ack <= 1'h0;
    end else if (wait_reg < ACK_DLY) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      cpu_hold_ack <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/drb_arbiter_sva.sv ====
// checker: port relations of the refresh and bus arbiter
`timescale 1ns/10ps
`default_nettype none
module drb_arbiter_sva
  import drb_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pready,
  input wire logic            cpu_hold,
  input wire logic            cpu_hold_ack,
  input wire logic            isa_hold_request,
  input wire logic            isa_grant_ack,
  input wire logic            vl_bus_grant_n,
  input wire logic            refresh_cmd_n,
  input wire logic            ras_n,
  input wire logic            cas_n,
  input wire logic            cpu_dram_req,
  input wire logic            cpu_row_phase,
  input wire logic [24:3]     cpu_addr,
  input wire logic [MA_W-1:0] dram_mux_address
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_apb_wait; psel && !penable |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("no ready after setup");
  property p_cbr; !refresh_cmd_n && $fell(ras_n) |-> !cas_n && $past(cas_n) == 1'h0; endproperty
  a_cbr: assert property (p_cbr) else $error("row strobe before column strobe");
  property p_ras_width; !refresh_cmd_n && $fell(ras_n) |-> !ras_n [*4] ##1 ras_n; endproperty
  a_ras_width: assert property (p_ras_width) else $error("refresh row pulse width");
  property p_grant_ack; $rose(isa_grant_ack) |-> cpu_hold_ack && cpu_hold; endproperty
  a_grant_ack: assert property (p_grant_ack) else $error("grant before cpu release");
  property p_grant_end; $fell(isa_hold_request) |-> ##[1:8] !isa_grant_ack; endproperty
  a_grant_end: assert property (p_grant_end) else $error("grant kept after request");
  property p_vl_hold; !vl_bus_grant_n |-> cpu_hold; endproperty
  a_vl_hold: assert property (p_vl_hold) else $error("vl grant without hold");
  property p_row; cpu_dram_req && cpu_row_phase && !cpu_hold
    |=> dram_mux_address[8:0] == $past(cpu_addr[20:12]); endproperty
  a_row: assert property (p_row) else $error("row address mismatch");
  property p_col; cpu_dram_req && !cpu_row_phase && !cpu_hold
    |=> dram_mux_address[8:2] == $past(cpu_addr[11:5]); endproperty
  a_col: assert property (p_col) else $error("column address mismatch");
  c_refresh: cover property (!refresh_cmd_n);
  c_isa: cover property (isa_grant_ack);
  c_vl: cover property (!vl_bus_grant_n);
endmodule
bind drb_arbiter drb_arbiter_sva u_drb_arbiter_sva (.*);
`default_nettype wire

// ==== tb/drb_arbiter_bench.sv ====
// bench: self-checking test of the refresh and bus arbiter
`timescale 1ns/10ps
`default_nettype none
module drb_arbiter_bench;
  import drb_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, timer_refresh_output, lclk;
  logic            isa_hold_request, vl_bus_request_n, vl_transaction_done, cpu_hold_ack;
  logic            dma8_addr_enable_n, dma16_addr_enable_n, cpu_dram_req, cpu_row_phase;
  logic            burst_start, pready, pslverr, cpu_hold, isa_grant_ack, vl_bus_grant_n;
  logic            refresh_cmd_n, at_refresh_req, cpu_wait, ras_n, cas_n, err;
  logic            cpu_at_req, cpu_castout_busy, burst_step;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [24:3]     cpu_addr;
  logic [MA_W-1:0] dram_mux_address;
  int              fails, tests_run;

  drb_arbiter #(.REFRESH_CNT(16)) u_drb_arbiter (.*, .isa_master_refresh_n(1'h1),
    .isa_mem_cmd_n(1'h1));
  drb_cpu_model #(.ACK_DLY(3)) u_drb_cpu_model (.pclk, .presetn, .cpu_hold, .cpu_hold_ack);

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) lclk <= ~lclk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wt(ref logic s, input logic v);
    for (int i = 0; i < 80 && s !== v; i++) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic tm;
    timer_refresh_output <= 1'h1;
    repeat (6) @(posedge pclk);
    timer_refresh_output <= 1'h0;
  endtask
  task automatic summarize;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    apb(1'h0, DRB_CTRL_ADDR, 32'h0);
    chk(rd, CTRL_RESET_VAL);
    apb(1'h1, DRB_CTRL_ADDR, 32'h2F);
    apb(1'h0, DRB_CTRL_ADDR, 32'h0);
    chk(rd, 32'h2F);
    apb(1'h0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'h1, DRB_CTRL_ADDR, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_normal;
    tm();
    wt(cas_n, 1'h0);
    chk({cpu_hold, cpu_hold_ack, refresh_cmd_n, ras_n}, 32'hD);
    wt(ras_n, 1'h0);
    chk(cas_n, 32'h0);
    wt(cpu_hold, 1'h0);
    $display("t_normal done");
  endtask
  task automatic t_hidden;
    logic hs, rl, wl;
    hs = 1'h0;
    rl = 1'h0;
    wl = 1'h0;
    apb(1'h1, DRB_CTRL_ADDR, 32'h1);
    cpu_at_req <= 1'h1;
    timer_refresh_output <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (i == 6) timer_refresh_output <= 1'h0;
      hs |= cpu_hold;
      rl |= !ras_n;
      wl |= cpu_wait;
    end
    cpu_at_req <= 1'h0;
    chk({hs, rl, wl}, 32'h3);
    apb(1'h1, DRB_CTRL_ADDR, 32'h0);
    $display("t_hidden done");
  endtask
  task automatic t_isa;
    isa_hold_request <= 1'h1;
    dma8_addr_enable_n <= 1'h0;
    wt(isa_grant_ack, 1'h1);
    chk({isa_grant_ack, cpu_hold, cpu_hold_ack}, 32'h7);
    tm();
    apb(1'h0, DRB_STATUS_ADDR, 32'h0);
    chk(rd[8:4], 32'h5);
    dma8_addr_enable_n <= 1'h1;
    dma16_addr_enable_n <= 1'h0;
    apb(1'h0, DRB_STATUS_ADDR, 32'h0);
    chk(rd[8:6], 32'h2);
    dma16_addr_enable_n <= 1'h1;
    apb(1'h0, DRB_STATUS_ADDR, 32'h0);
    chk({rd[8:6], isa_grant_ack}, 32'h9);
    isa_hold_request <= 1'h0;
    wt(refresh_cmd_n, 1'h0);
    chk({isa_grant_ack, refresh_cmd_n}, 32'h0);
    wt(cpu_hold, 1'h0);
    $display("t_isa done");
  endtask
  task automatic t_vl(input logic fifo);
    apb(1'h1, DRB_CTRL_ADDR, {30'h0, fifo, 1'h0});
    vl_bus_request_n <= 1'h0;
    wt(vl_bus_grant_n, 1'h0);
    chk({vl_bus_grant_n, cpu_hold}, 32'h1);
    tm();
    repeat (20) @(posedge pclk);
    chk(vl_bus_grant_n, {31'h0, !fifo});
    vl_transaction_done <= 1'h1;
    vl_bus_request_n <= 1'h1;
    @(posedge pclk);
    vl_transaction_done <= 1'h0;
    wt(refresh_cmd_n, 1'h0);
    chk(refresh_cmd_n, 32'h0);
    wt(cpu_hold, 1'h0);
    $display("t_vl done");
  endtask
  task automatic t_addr;
    logic [24:3] a;
    logic [10:0] m;
    a = 22'h2A5A5B;
    cpu_addr <= a;
    cpu_dram_req <= 1'h1;
    for (int s = 0; s < 3; s++) begin
      m = {s == 2, s > 0, 9'h1FF};
      apb(1'h1, DRB_CTRL_ADDR, 32'(s << 4));
      cpu_row_phase <= 1'h1;
      repeat (3) @(posedge pclk);
      chk(dram_mux_address & m, {a[23], a[21], a[20:12]} & m);
      cpu_row_phase <= 1'h0;
      burst_start <= 1'h1;
      @(posedge pclk);
      burst_start <= 1'h0;
      repeat (2) @(posedge pclk);
      chk(dram_mux_address & m, {a[24], a[22], a[11:3]} & m);
    end
    cpu_dram_req <= 1'h0;
    $display("t_addr done");
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, timer_refresh_output, lclk} = '0;
    {isa_hold_request, vl_transaction_done, cpu_dram_req, cpu_row_phase, burst_start} = '0;
    {cpu_at_req, cpu_castout_busy, burst_step} = '0;
    {paddr, pwdata, cpu_addr} = '0;
    {vl_bus_request_n, dma8_addr_enable_n, dma16_addr_enable_n} = '1;
    fails = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_normal();
    t_hidden();
    t_isa();
    t_vl(1'h0);
    t_vl(1'h1);
    t_addr();
    summarize();
  end
  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
